// file: hdl/exit_unit_pkg.sv
// Constants for the processor error-exit unit.
// Assumes a 60-bit word machine with 18-bit program addresses.
package exit_unit_pkg;
   localparam int WORD_W = 60;
   localparam int ADDR_W = 18;
   localparam int OPC_W = 9;
   localparam int CODE_W = 6;
   localparam int STAT_W = 30;
   // Exchange package word holding the exit-mode bits
   localparam logic [3:0] EXIT_MODE_WORD = 4'h3;
   // Exit-mode bit positions inside that word
   localparam int EM_RANGE_BIT = 48;
   localparam int EM_INF_BIT = 49;
   localparam int EM_IND_BIT = 50;
   // Exit condition word field layout
   localparam int EC_LSB = 48;
   localparam int PADDR_LSB = 30;
   localparam int STAT_LSB = 0;
   // Exit codes (octal as printed)
   localparam logic [5:0] EC_ILLEGAL = 6'h00;
   localparam logic [5:0] EC_RANGE = 6'h01;
   localparam logic [5:0] EC_INF = 6'h02;
   localparam logic [5:0] EC_IND = 6'h04;
   localparam logic [5:0] EC_PROC_MALF = 6'h10;
   localparam logic [5:0] EC_HW_MALF = 6'h37;
   // Operation codes (octal as printed)
   localparam logic [8:0] OP_017 = 9'h00f;
   localparam logic [8:0] OP_011 = 9'h009;
   localparam logic [8:0] OP_012 = 9'h00a;
   localparam logic [8:0] OP_013 = 9'h00b;
   localparam logic [8:0] OP_014 = 9'h00c;
   localparam logic [8:0] OP_015 = 9'h00d;
   localparam logic [8:0] OP_464 = 9'h134;
   localparam logic [8:0] OP_467 = 9'h137;
   localparam logic [1:0] PARCEL_FIRST = 2'h0;
   localparam logic [1:0] PARCEL_LAST = 2'h3;
   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_EXCHANGE = 2'b01,
      ACT_EXEC_STOP = 2'b10,
      ACT_EXEC_RETURN = 2'b11
   } exit_action_t;
endpackage

// file: hdl/illegal_decode.sv
// Combinational illegal-instruction classifier.
// Assumes opcode, parcel and length come from the decode stage.
`timescale 1ns/1ps
`default_nettype none
module illegal_decode
   import exit_unit_pkg::*;
(
   input wire logic [OPC_W-1:0] opcode,
   input wire logic [1:0] parcel,
   input wire logic longInstr,
   input wire logic badParam,
   input wire logic extendedMemoryEn,
   output logic illegal
);
   logic opc017, parcelCheck, extMemOp;
   always_comb begin
      opc017 = (opcode == OP_017);
      parcelCheck = ((opcode == OP_011) || (opcode == OP_012) || (opcode == OP_013) ||
         ((opcode >= OP_464) && (opcode <= OP_467))) && (parcel != PARCEL_FIRST);
      extMemOp = ((opcode == OP_011) || (opcode == OP_012) || (opcode == OP_014) ||
         (opcode == OP_015)) && !extendedMemoryEn;
      illegal = opc017 || parcelCheck || extMemOp || badParam ||
         (longInstr && (parcel == PARCEL_LAST));
   end
endmodule
`default_nettype wire

// file: hdl/cpu_error_exit_unit.sv
// Processor error-exit unit: classifies errors, gates by exit mode, forms exit word.
// Assumes one error report per cycle with qualifying valid strobes from the pipeline.
//
// Summary of operation
// - Illegal instruction or fetch/branch range error always interrupts.
// - Other errors, except hardware errors, interrupt only when their exit-mode bit is set.
// - Exit-mode bits are taken from exchange package word 3.
// - Bad opcode, bad parameter or word-spanning instruction is illegal.
// - Illegal in job mode exchanges to monitor; in monitor mode stops.
// - Opcode 017 is always illegal.
// - Opcodes 011,012,013,464-467 illegal unless at first parcel.
// - Opcodes 011,012,014,015 illegal when extended memory disabled.
// - Any 30-bit instruction starting at last parcel is illegal.
// - Exit condition is a 6-bit code in the reference word.
// - Codes: 00 illegal, 01 range, 02 inf, 04 ind, 20, 67.
// - Bit 48 range, 49 infinite, 50 indefinite exit enables.
// - Stored program address may already point past the fault.
// - Maintenance status occupies bits 0 through 29 of exit word.
// - Hardware errors jump to executive; job returns to monitor, monitor halts.
// - Monitor-mode illegal: not executed, store address and 00, stop.
// - Enabled increment-read range error: operand kept, address held, code 01.
// - Disabled increment-read range error: read suppressed, execution continues.
// - Enabled increment-write range error: write blocked, code 01, interrupt.
// - Disabled increment-write range error: write suppressed, execution continues.
// - Fetch or branch range error inhibits execution, stores code 01.
// - Job-mode exit other than hardware error stores word, exchanges to monitor, sets monitor flag.
// - Conditional error with clear exit bit is ignored in both modes.
`timescale 1ns/1ps
`default_nettype none
module cpu_error_exit_unit
   import exit_unit_pkg::*;
#(
   parameter int AW = ADDR_W
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic xpkgWrite,
   input wire logic [3:0] xpkgWordIdx,
   input wire logic [WORD_W-1:0] xpkgWordData,
   input wire logic extendedMemoryEn,
   input wire logic monitorFlagIn,
   input wire logic instrValid,
   input wire logic [OPC_W-1:0] opcode,
   input wire logic [1:0] parcel,
   input wire logic longInstr,
   input wire logic badParam,
   input wire logic [AW-1:0] progAddr,
   input wire logic fetchRangeErr,
   input wire logic [AW-1:0] fetchAddr,
   input wire logic incReadRangeErr,
   input wire logic incWriteRangeErr,
   input wire logic [AW-1:0] incAddr,
   input wire logic fpInfinite,
   input wire logic fpIndefinite,
   input wire logic hwParityErr,
   input wire logic hwDoubleBitErr,
   input wire logic procMalfunction,
   input wire logic [STAT_W-1:0] maintStatus,
   output logic exitStore,
   output logic [WORD_W-1:0] exitWord,
   output logic [CODE_W-1:0] exitCode,
   output logic exchangeToMonitor,
   output logic setMonitorFlag,
   output logic execInterrupt,
   output logic cpuStop,
   output logic inhibitExec,
   output logic suppressRead,
   output logic suppressWrite,
   output logic holdOperand,
   output logic loadAddrReg,
   output logic [AW-1:0] addrRegValue,
   output logic [2:0] exitModeBits
);
   logic [2:0] exitMode_r, exitMode_nxt;
   logic exitStore_r, exitStore_nxt;
   logic [WORD_W-1:0] exitWord_r, exitWord_nxt;
   logic [CODE_W-1:0] exitCode_r, exitCode_nxt;
   logic exch_r, exch_nxt, setMf_r, setMf_nxt;
   logic execInt_r, execInt_nxt, stop_r, stop_nxt;
   logic inhibit_r, inhibit_nxt, supRd_r, supRd_nxt, supWr_r, supWr_nxt;
   logic hold_r, hold_nxt, loadA_r, loadA_nxt;
   logic [AW-1:0] aVal_r, aVal_nxt;
   logic illegal;
   logic emRange, emInf, emInd;
   logic take;
   exit_action_t action;
   logic [CODE_W-1:0] code;
   logic [AW-1:0] storeAddr;
   logic [WORD_W-1:0] word;

   illegal_decode decoder (
      .opcode(opcode),
      .parcel(parcel),
      .longInstr(longInstr),
      .badParam(badParam),
      .extendedMemoryEn(extendedMemoryEn),
      .illegal(illegal)
   );

   // Exit-mode capture from the exchange package
   always_comb begin
      exitMode_nxt = exitMode_r;
      if (xpkgWrite && (xpkgWordIdx == EXIT_MODE_WORD)) begin
         exitMode_nxt = {xpkgWordData[EM_IND_BIT], xpkgWordData[EM_INF_BIT],
            xpkgWordData[EM_RANGE_BIT]};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exitMode_r <= 3'h0;
      end else begin
         exitMode_r <= exitMode_nxt;
      end
   end

   // Classification and priority
   always_comb begin
      emRange = exitMode_r[0];
      emInf = exitMode_r[1];
      emInd = exitMode_r[2];
      take = 1'b0;
      action = ACT_NONE;
      code = EC_ILLEGAL;
      storeAddr = progAddr;
      inhibit_nxt = 1'b0;
      supRd_nxt = 1'b0;
      supWr_nxt = 1'b0;
      hold_nxt = 1'b0;
      loadA_nxt = 1'b0;
      aVal_nxt = aVal_r;
      if (hwParityErr || hwDoubleBitErr) begin
         take = 1'b1;
         code = EC_PROC_MALF;
         action = monitorFlagIn ? ACT_EXEC_STOP : ACT_EXEC_RETURN;
      end else if (procMalfunction) begin
         take = 1'b1;
         code = EC_HW_MALF;
         action = monitorFlagIn ? ACT_EXEC_STOP : ACT_EXEC_RETURN;
      end else if (fetchRangeErr) begin
         take = 1'b1;
         code = EC_RANGE;
         storeAddr = fetchAddr;
         inhibit_nxt = 1'b1;
      end else if (instrValid && illegal) begin
         take = 1'b1;
         code = EC_ILLEGAL;
         inhibit_nxt = 1'b1;
      end else if (incReadRangeErr) begin
         supRd_nxt = 1'b1;
         hold_nxt = 1'b1;
         if (emRange) begin
            take = 1'b1;
            code = EC_RANGE;
            loadA_nxt = 1'b1;
            aVal_nxt = incAddr;
         end
      end else if (incWriteRangeErr) begin
         supWr_nxt = 1'b1;
         if (emRange) begin
            take = 1'b1;
            code = EC_RANGE;
            loadA_nxt = 1'b1;
            aVal_nxt = incAddr;
         end
      end else if (fpInfinite && emInf) begin
         take = 1'b1;
         code = EC_INF;
      end else if (fpIndefinite && emInd) begin
         take = 1'b1;
         code = EC_IND;
      end
      if (take && (action == ACT_NONE)) begin
         action = monitorFlagIn ? ACT_EXEC_STOP : ACT_EXCHANGE;
      end
      word = '0;
      word[EC_LSB +: CODE_W] = code;
      word[PADDR_LSB +: AW] = storeAddr;
      word[STAT_LSB +: STAT_W] = maintStatus;
      exitStore_nxt = take;
      exitWord_nxt = take ? word : exitWord_r;
      exitCode_nxt = take ? code : exitCode_r;
      exch_nxt = (action == ACT_EXCHANGE);
      setMf_nxt = (action == ACT_EXCHANGE) || (action == ACT_EXEC_RETURN);
      execInt_nxt = (action == ACT_EXEC_STOP) || (action == ACT_EXEC_RETURN);
      stop_nxt = stop_r || (action == ACT_EXEC_STOP);
      if (!take) begin
         stop_nxt = stop_r && !xpkgWrite;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exitStore_r <= 1'b0;
         exitWord_r <= '0;
         exitCode_r <= '0;
         exch_r <= 1'b0;
         setMf_r <= 1'b0;
         execInt_r <= 1'b0;
         stop_r <= 1'b0;
         inhibit_r <= 1'b0;
         supRd_r <= 1'b0;
         supWr_r <= 1'b0;
         hold_r <= 1'b0;
         loadA_r <= 1'b0;
         aVal_r <= '0;
      end else begin
         exitStore_r <= exitStore_nxt;
         exitWord_r <= exitWord_nxt;
         exitCode_r <= exitCode_nxt;
         exch_r <= exch_nxt;
         setMf_r <= setMf_nxt;
         execInt_r <= execInt_nxt;
         stop_r <= stop_nxt;
         inhibit_r <= inhibit_nxt;
         supRd_r <= supRd_nxt;
         supWr_r <= supWr_nxt;
         hold_r <= hold_nxt;
         loadA_r <= loadA_nxt;
         aVal_r <= aVal_nxt;
      end
   end

   assign exitStore = exitStore_r;
   assign exitWord = exitWord_r;
   assign exitCode = exitCode_r;
   assign exchangeToMonitor = exch_r;
   assign setMonitorFlag = setMf_r;
   assign execInterrupt = execInt_r;
   assign cpuStop = stop_r;
   assign inhibitExec = inhibit_r;
   assign suppressRead = supRd_r;
   assign suppressWrite = supWr_r;
   assign holdOperand = hold_r;
   assign loadAddrReg = loadA_r;
   assign addrRegValue = aVal_r;
   assign exitModeBits = exitMode_r;
endmodule
`default_nettype wire

// file: verif/cpu_error_exit_unit_assertions.sv
// Checker: error-exit unit port assertions.
// Assumes one clock and async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cpu_error_exit_unit_assertions
   import exit_unit_pkg::*;
#(parameter int AW = ADDR_W)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic xpkgWrite,
   input wire logic monitorFlagIn,
   input wire logic instrValid,
   input wire logic fetchRangeErr,
   input wire logic incReadRangeErr,
   input wire logic incWriteRangeErr,
   input wire logic hwParityErr,
   input wire logic hwDoubleBitErr,
   input wire logic procMalfunction,
   input wire logic fpInfinite,
   input wire logic fpIndefinite,
   input wire logic exitStore,
   input wire logic execInterrupt,
   input wire logic cpuStop,
   input wire logic setMonitorFlag,
   input wire logic inhibitExec,
   input wire logic suppressRead,
   input wire logic suppressWrite,
   input wire logic [3:0] xpkgWordIdx,
   input wire logic [WORD_W-1:0] xpkgWordData,
   input wire logic [WORD_W-1:0] exitWord,
   input wire logic [AW-1:0] fetchAddr,
   input wire logic [AW-1:0] incAddr,
   input wire logic [AW-1:0] addrRegValue,
   input wire logic [STAT_W-1:0] maintStatus,
   input wire logic [CODE_W-1:0] exitCode,
   input wire logic [2:0] exitModeBits
);
   wire logic hw = hwParityErr | hwDoubleBitErr;
   wire logic hiPri = hw | procMalfunction | fetchRangeErr | instrValid;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence wrExit; incWriteRangeErr && exitModeBits[0] && !hiPri && !incReadRangeErr; endsequence
   sequence wrDone; exitStore && suppressWrite && exitCode == EC_RANGE; endsequence
   hw_exit_a: assert property (hw |=> exitStore && execInterrupt && exitCode == EC_PROC_MALF)
      else $error("hardware exit wrong");
   fetch_exit_a: assert property (fetchRangeErr && !hw && !procMalfunction
      |=> exitStore && inhibitExec && exitCode == EC_RANGE && exitWord[47:30] == $past(fetchAddr))
      else $error("fetch range exit wrong");
   mode_load_a: assert property (xpkgWrite && xpkgWordIdx == EXIT_MODE_WORD
      |=> exitModeBits == $past(xpkgWordData[50:48])) else $error("exit mode load wrong");
   mode_keep_a: assert property (xpkgWrite && xpkgWordIdx != EXIT_MODE_WORD
      |=> $stable(exitModeBits)) else $error("exit mode changed");
   fp_gate_a: assert property (fpInfinite && !exitModeBits[1] && !hiPri && !fpIndefinite
      && !incReadRangeErr && !incWriteRangeErr |=> !exitStore) else $error("gated exit taken");
   rd_skip_a: assert property (incReadRangeErr && !exitModeBits[0] && !hiPri
      |=> suppressRead) else $error("read not suppressed");
   wr_block_a: assert property (wrExit ##1 wrDone |-> addrRegValue == $past(incAddr))
      else $error("write exit wrong");
   job_flag_a: assert property (exitStore |-> setMonitorFlag == !$past(monitorFlagIn))
      else $error("monitor flag wrong");
   mon_stop_a: assert property (exitStore && $past(monitorFlagIn) |-> cpuStop && execInterrupt)
      else $error("monitor exit did not stop");
   word_fmt_a: assert property (exitStore |-> exitWord[53:48] == exitCode
      && exitWord[59:54] == 6'h00 && exitWord[29:0] == $past(maintStatus)) else $error("exit word wrong");
endmodule
bind cpu_error_exit_unit cpu_error_exit_unit_assertions #(.AW(AW)) u_chk (.*);
`default_nettype wire

// file: verif/exec_state_model.sv
// Executive state and reference word store.
// Assumes exit word arrives with the store pulse.
`timescale 1ns/1ps
`default_nettype none
module exec_state_model
   import exit_unit_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic exitStore,
   input wire logic setMonitorFlag,
   input wire logic resume,
   input wire logic resumeMon,
   input wire logic [WORD_W-1:0] exitWord,
   output logic monitorFlag,
   output logic [WORD_W-1:0] refWord
);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         monitorFlag <= 1'b0;
         refWord <= '0;
      end else begin
         if (exitStore) refWord <= exitWord;
         if (setMonitorFlag) monitorFlag <= 1'b1;
         else if (resume) monitorFlag <= resumeMon;
      end
   end
endmodule
`default_nettype wire

// file: verif/cpu_error_exit_unit_tb.sv
// Bench: random error reports into the exit unit.
// Assumes the executive model drives the mode.
`timescale 1ns/1ps
`default_nettype none
module cpu_error_exit_unit_tb
   import exit_unit_pkg::*;
;
   logic clk = '0, nrst = '0, xpkgWrite = '0, extendedMemoryEn = '0, instrValid = '0, longInstr = '0;
   logic badParam = '0, fetchRangeErr = '0, incReadRangeErr = '0, incWriteRangeErr = '0;
   logic fpInfinite = '0, fpIndefinite = '0, hwParityErr = '0, hwDoubleBitErr = '0;
   logic procMalfunction = '0, resume = '0, resumeMon = '0;
   logic [3:0] xpkgWordIdx = '0;
   logic [1:0] parcel = '0;
   logic [OPC_W-1:0] opcode = '0;
   logic [WORD_W-1:0] xpkgWordData = '0, exitWord, refWord;
   logic [ADDR_W-1:0] progAddr = '0, fetchAddr = '0, incAddr = '0, addrRegValue;
   logic [STAT_W-1:0] maintStatus = '0;
   logic [CODE_W-1:0] exitCode;
   logic [2:0] exitModeBits, em = '0;
   logic monitorFlagIn, exitStore, exchangeToMonitor, setMonitorFlag, execInterrupt, cpuStop;
   logic inhibitExec, suppressRead, suppressWrite, holdOperand, loadAddrReg;
   int errTotal = 0, compares = 0, cycles = 0;
   cpu_error_exit_unit u_cpu_error_exit_unit (.*);
   exec_state_model u_exec_state_model (.clk, .nrst, .exitStore, .setMonitorFlag, .resume,
      .resumeMon, .exitWord, .monitorFlag(monitorFlagIn), .refWord);
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errTotal++;
         results();
      end
   end
   task results();
      $display("compares %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         errTotal++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task step();
      @(posedge clk);
      #2;
   endtask
   function automatic logic isIllegal(input logic [8:0] op, input logic [1:0] pc, input logic lng, bad, ext);
      logic posOp, memOp;
      posOp = op inside {OP_011, OP_012, OP_013} || (op >= OP_464 && op <= OP_467);
      memOp = op inside {OP_011, OP_012, OP_014, OP_015};
      return bad || op == OP_017 || (lng && pc == PARCEL_LAST) || (posOp && pc != PARCEL_FIRST) || (memOp && !ext);
   endfunction
   function automatic logic [CODE_W-1:0] expCode(input int k);
      case (k)
         0, 1: return EC_PROC_MALF;
         2: return EC_HW_MALF;
         4: return EC_ILLEGAL;
         7: return EC_INF;
         8: return EC_IND;
         default: return EC_RANGE;
      endcase
   endfunction
   task drive(input int k, input logic on);
      case (k)
         0: hwParityErr = on;
         1: hwDoubleBitErr = on;
         2: procMalfunction = on;
         3: fetchRangeErr = on;
         4: instrValid = on;
         5: incReadRangeErr = on;
         6: incWriteRangeErr = on;
         7: fpInfinite = on;
         default: fpIndefinite = on;
      endcase
   endtask
   task trial(input int k, input int extra);
      logic mon, store;
      logic [WORD_W-1:0] word;
      xpkgWordIdx = 4'($urandom_range(2, 4));
      xpkgWordData = WORD_W'({$urandom, $urandom});
      if (xpkgWordIdx == EXIT_MODE_WORD) em = xpkgWordData[50:48];
      xpkgWrite = 1'b1;
      step();
      xpkgWrite = 1'b0;
      mon = 1'($urandom);
      resume = 1'b1;
      resumeMon = mon;
      step();
      resume = 1'b0;
      chk("exitModeBits", 60'(exitModeBits), 60'(em));
      opcode = ($urandom % 2) ? 9'($urandom_range(9, 15)) : 9'($urandom_range(304, 311));
      parcel = 2'($urandom);
      longInstr = 1'($urandom);
      badParam = ($urandom % 8) == 0;
      extendedMemoryEn = 1'($urandom);
      {progAddr, fetchAddr} = 36'({$urandom, $urandom});
      incAddr = ADDR_W'($urandom);
      maintStatus = STAT_W'($urandom);
      drive(k, 1'b1);
      if (extra > k) drive(extra, 1'b1);
      store = k < 4 || (k == 4 && isIllegal(opcode, parcel, longInstr, badParam, extendedMemoryEn))
         || (k inside {5, 6} && em[0]) || (k == 7 && em[1]) || (k == 8 && em[2]);
      word = {6'h00, expCode(k), (k == 3) ? fetchAddr : progAddr, maintStatus};
      step();
      drive(k, 1'b0);
      drive(extra, 1'b0);
      chk("exitStore", 60'(exitStore), 60'(store));
      if (store) chk("exitWord", exitWord, word);
      if (store) chk("setMonitorFlag", 60'(setMonitorFlag), 60'(!mon));
      if (store) chk("cpuStop", 60'(cpuStop), 60'(mon));
      if (store && k inside {5, 6}) chk("addrRegValue", 60'(addrRegValue), 60'(incAddr));
      if (!store && k inside {5, 6}) chk("suppress", 60'(k == 5 ? suppressRead : suppressWrite), 60'h1);
      chk("inhibitExec", 60'(inhibitExec), 60'(k == 3 || (k == 4 && store)));
      chk("exchangeToMonitor", 60'(exchangeToMonitor), 60'(store && !mon && k > 2));
      chk("execInterrupt", 60'(execInterrupt), 60'(store && (mon || k < 3)));
      chk("holdOperand", 60'(holdOperand), 60'(k == 5));
      chk("loadAddrReg", 60'(loadAddrReg), 60'(store && k inside {5, 6}));
      if (store) chk("exitCode", 60'(exitCode), 60'(expCode(k)));
      step();
      if (store) chk("refWord", refWord, word);
   endtask
   initial begin
      int k;
      void'($urandom(32'ha4ee));
      repeat (3) @(posedge clk);
      #2;
      nrst = 1'b1;
      trial(0, 7);
      trial(3, 4);
      trial(2, 5);
      repeat (400) begin
         k = $urandom_range(0, 8);
         trial(k, (k < 4 && $urandom % 3 == 0) ? $urandom_range(k + 1, 8) : k);
      end
      results();
   end
endmodule
`default_nettype wire
